// File: include/noload_cfg.svh
// timing-free constants of the phase no-load detector: offsets, fields, reset values
`ifndef NOLOAD_CFG_SVH
`define NOLOAD_CFG_SVH
`define OFS_ACTIVE_THR 8'h00
`define OFS_REACTIVE_THR 8'h04
`define OFS_APPARENT_THR 8'h08
`define OFS_PHASE_STATE 8'h0C
`define OFS_FLAGS_SECOND 8'h10
`define OFS_ENABLE_SECOND 8'h14
`define FLAG_TOTAL_BIT 0
`define FLAG_FUND_BIT 1
`define FLAG_APP_BIT 2
`define PHASE_FUND_LSB 3
`define PHASE_APP_LSB 6
`define THR_RESET 24'h000000
`define FULL_SCALE_POWER 28'h1FF6A6B
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// File: include/noload_pkg.sv
// types shared by the phase no-load detector
package noload_pkg;
    typedef logic signed [27:0] dsp_word_type;
    typedef enum logic [1:0] {
        wr_idle,
        wr_resp
    } wr_state_type;
endpackage

// File: core/phase_noload_detect.sv
// per-phase fundamental and apparent no-load detectors with axi4-lite registers
`timescale 1ns/10ps
`include "noload_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - phase is fundamental no-load when both |P| and |Q| are at or below thresholds
// - fundamental no-load phase blocks its fundamental energy accumulation and pulses
// - fundamental detector shares the total-power active and reactive thresholds
// - a negative active or reactive threshold disables fundamental detection
// - any phase change in fundamental no-load sets flag bit 1
// - phase state bits 5:3 hold fundamental no-load, A lowest, with flag
// - enable bit 1 lets fundamental flag pull interrupt line low
// - writing one to a no-load flag clears it, releasing the line
// - phase is apparent no-load when |S| is at or below its threshold
// - apparent no-load phase blocks its apparent energy accumulation and pulses
// - apparent threshold is signed 24-bit, scaled against full-scale power
// - negative apparent threshold disables apparent detection
// - threshold reads as 32 bits, top eight zero, sign-extended to 28 internally
// - any phase change in apparent no-load sets flag bit 2
// - phase state bits 8:6 hold apparent no-load, A lowest, with flag
// - enable bit 2 lets apparent flag pull interrupt line low
// - bus carries words; comparisons run at 28-bit processing width
// - flags set regardless of enable bits
// - line stays low until every enabled pending flag is cleared
//////////////////////////////////////////////////////////////////////////////
module phase_noload_detect (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // per-phase powers from the dsp, 28-bit signed, index 0 is phase a
    input wire logic [27:0] fund_active_power [3],
    input wire logic [27:0] fund_reactive_power [3],
    input wire logic [27:0] apparent_power [3],
    input wire logic power_valid,
    // total-power no-load event from the neighbouring detector
    input wire logic total_noload_event,
    // accumulation gates toward energy registers and energy_pulse_outputs
    output logic [2:0] fund_accumulate_en,
    output logic [2:0] apparent_accumulate_en,
    // interrupt
    output logic interrupt_line_second_n,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [23:0] active_power_noload_threshold;
    logic [23:0] reactive_power_noload_threshold;
    logic [23:0] apparent_noload_threshold;
    logic [2:0] fundamental_noload_phase_bits;
    logic [2:0] apparent_noload_phase_bits;
    logic [2:0] flags;
    logic [2:0] enables;
    logic [2:0] next_fund_bits;
    logic [2:0] next_app_bits;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held;
    logic w_held;
    noload_pkg::wr_state_type wr_state;

    //////////////////////////////////////////////////////////////////////////
    // threshold widening to the dsp width
    noload_pkg::dsp_word_type act_thr28;
    noload_pkg::dsp_word_type react_thr28;
    noload_pkg::dsp_word_type app_thr28;
    assign act_thr28 = {{4{active_power_noload_threshold[23]}},
        active_power_noload_threshold};
    assign react_thr28 = {{4{reactive_power_noload_threshold[23]}},
        reactive_power_noload_threshold};
    assign app_thr28 = {{4{apparent_noload_threshold[23]}}, apparent_noload_threshold};
    wire fund_det_on = !act_thr28[27] && !react_thr28[27];
    wire app_det_on = !app_thr28[27];

    function automatic logic [27:0] mag28(input logic [27:0] v);
        mag28 = v[27] ? 28'(-v) : v;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // per-phase comparison
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_fund_bits[i] = fund_det_on
                && (mag28(fund_active_power[i]) <= act_thr28)
                && (mag28(fund_reactive_power[i]) <= react_thr28);
            next_app_bits[i] = app_det_on
                && (mag28(apparent_power[i]) <= app_thr28);
        end
    end

    wire fund_change = power_valid && (next_fund_bits != fundamental_noload_phase_bits);
    wire app_change = power_valid && (next_app_bits != apparent_noload_phase_bits);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fundamental_noload_phase_bits <= 3'h0;
            apparent_noload_phase_bits <= 3'h0;
        end else if (power_valid) begin
            fundamental_noload_phase_bits <= next_fund_bits;
            apparent_noload_phase_bits <= next_app_bits;
        end
    end

    assign fund_accumulate_en = ~fundamental_noload_phase_bits;
    assign apparent_accumulate_en = ~apparent_noload_phase_bits;

    //////////////////////////////////////////////////////////////////////////
    // axi4-lite write path: address and data taken in either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    assign s_axi_awready = (wr_state == noload_pkg::wr_idle) && !aw_held;
    assign s_axi_wready = (wr_state == noload_pkg::wr_idle) && !w_held;
    wire wr_fire = (wr_state == noload_pkg::wr_idle) && (aw_held || aw_take)
        && (w_held || w_take);
    wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire wr_known = wr_addr == `OFS_ACTIVE_THR || wr_addr == `OFS_REACTIVE_THR
        || wr_addr == `OFS_APPARENT_THR || wr_addr == `OFS_PHASE_STATE
        || wr_addr == `OFS_FLAGS_SECOND || wr_addr == `OFS_ENABLE_SECOND;
    wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [31:0] wbits = wr_data & wmask;
    wire wr_flags = wr_fire && wr_addr == `OFS_FLAGS_SECOND;
    wire wr_enable = wr_fire && wr_addr == `OFS_ENABLE_SECOND;

    function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] nw,
        input logic [31:0] m);
        merge24 = (old & ~m[23:0]) | (nw[23:0] & m[23:0]);
    endfunction

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_state <= noload_pkg::wr_idle;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
        end else if (wr_fire) begin
            wr_state <= noload_pkg::wr_resp;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
        end else if (wr_state == noload_pkg::wr_resp) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                wr_state <= noload_pkg::wr_idle;
            end
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            active_power_noload_threshold <= `THR_RESET;
            reactive_power_noload_threshold <= `THR_RESET;
            apparent_noload_threshold <= `THR_RESET;
            enables <= 3'h0;
        end else if (wr_fire) begin
            if (wr_addr == `OFS_ACTIVE_THR)
                active_power_noload_threshold <= merge24(active_power_noload_threshold,
                    wbits, wmask);
            if (wr_addr == `OFS_REACTIVE_THR)
                reactive_power_noload_threshold <= merge24(reactive_power_noload_threshold,
                    wbits, wmask);
            if (wr_addr == `OFS_APPARENT_THR)
                apparent_noload_threshold <= merge24(apparent_noload_threshold, wbits, wmask);
            if (wr_enable)
                enables <= (enables & ~wmask[2:0]) | wbits[2:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // sticky event flags; a new event wins over a same-cycle clear
    wire [2:0] flag_set = {app_change, fund_change, total_noload_event};
    wire [2:0] flag_clr = wr_flags ? wbits[2:0] : 3'h0;
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            flags <= 3'h0;
        else
            flags <= (flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            interrupt_line_second_n <= 1'b1;
        else
            interrupt_line_second_n <= ~|(flags & enables);
    end

    //////////////////////////////////////////////////////////////////////////
    // axi4-lite read path
    wire [31:0] phase_word = {23'h000000, apparent_noload_phase_bits,
        fundamental_noload_phase_bits, 3'h0};
    wire rd_known = s_axi_araddr == `OFS_ACTIVE_THR || s_axi_araddr == `OFS_REACTIVE_THR
        || s_axi_araddr == `OFS_APPARENT_THR || s_axi_araddr == `OFS_PHASE_STATE
        || s_axi_araddr == `OFS_FLAGS_SECOND || s_axi_araddr == `OFS_ENABLE_SECOND;
    wire [31:0] rd_word =
        s_axi_araddr == `OFS_ACTIVE_THR ? {8'h00, active_power_noload_threshold} :
        s_axi_araddr == `OFS_REACTIVE_THR ? {8'h00, reactive_power_noload_threshold} :
        s_axi_araddr == `OFS_APPARENT_THR ? {8'h00, apparent_noload_threshold} :
        s_axi_araddr == `OFS_PHASE_STATE ? phase_word :
        s_axi_araddr == `OFS_FLAGS_SECOND ? {29'h00000000, flags} :
        s_axi_araddr == `OFS_ENABLE_SECOND ? {29'h00000000, enables} : 32'h00000000;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_known ? `AXI_OKAY : `AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // assertions
    a_fund_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fund_change |=> flags[1]) else $error("fundamental flag not set");
    a_app_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        app_change |=> flags[2]) else $error("apparent flag not set");
    a_fund_state_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
        power_valid |=> fundamental_noload_phase_bits == $past(next_fund_bits))
        else $error("fundamental state not tracked");
    a_app_state_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
        power_valid |=> apparent_noload_phase_bits == $past(next_app_bits))
        else $error("apparent state not tracked");
    a_fund_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (power_valid && act_thr28[27] && react_thr28[27]) |=> fundamental_noload_phase_bits == 3'h0)
        else $error("fundamental detect not disabled");
    a_app_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (power_valid && app_thr28[27]) |=> apparent_noload_phase_bits == 3'h0)
        else $error("apparent detect not disabled");
    a_irq_fund_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fund_change && enables[1] && !wr_enable) |=> ##1 !interrupt_line_second_n)
        else $error("line not low on fundamental event");
    a_irq_app_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (app_change && enables[2] && !wr_enable) |=> ##1 !interrupt_line_second_n)
        else $error("line not low on apparent event");
    a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_flags && wbits[1] && !fund_change) |=> !flags[1])
        else $error("flag not cleared by write one");
    a_irq_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|(flags & enables)) |=> !interrupt_line_second_n)
        else $error("line released with enabled flag pending");
    a_gate_fund: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fund_accumulate_en == ~fundamental_noload_phase_bits)
        else $error("fundamental gate wrong");
    c_fund_event: cover property (@(posedge ref_clk) disable iff (!rst_n) fund_change);
    c_app_event: cover property (@(posedge ref_clk) disable iff (!rst_n) app_change);
    c_irq_cycle: cover property (@(posedge ref_clk) disable iff (!rst_n)
        !interrupt_line_second_n ##[1:20] interrupt_line_second_n);
    c_clear_race: cover property (@(posedge ref_clk) disable iff (!rst_n)
        wr_flags && fund_change);
endmodule

// File: verif/testbench.sv
// self-checking bench for the phase no-load detector with a behavioural model
`timescale 1ns/10ps
`include "noload_cfg.svh"
module testbench;
    logic ref_clk, rst_n, power_valid, total_noload_event;
    logic [27:0] fund_active_power [3], fund_reactive_power [3], apparent_power [3];
    logic [2:0] fund_accumulate_en, apparent_accumulate_en;
    logic interrupt_line_second_n;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, st;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int fails, total_checks, cycles, thr_a, thr_r, thr_s, en, flags;
    int p [3], q [3], s [3];
    logic [2:0] fst, ast;
    phase_noload_detect dut_u (.*);
    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fails++;
            close_out();
        end
    end
    // handshakes are judged at the falling edge, where the readies have settled
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            @(posedge ref_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!((ta || !s_axi_awvalid) && (tw || !s_axi_wvalid)));
        do @(negedge ref_clk); while (!s_axi_bvalid);
        check({30'h0, s_axi_bresp}, (a > 8'h14) ? `AXI_SLVERR : `AXI_OKAY);
        // bready stays high between writes so the next call never re-raises it at the same edge
        @(posedge ref_clk);
        if (a == `OFS_FLAGS_SECOND) flags &= ~d;
        if (a == `OFS_ENABLE_SECOND) en = d[2:0];
        if (a == `OFS_ACTIVE_THR) thr_a = $signed(d[23:0]);
        if (a == `OFS_REACTIVE_THR) thr_r = $signed(d[23:0]);
        if (a == `OFS_APPARENT_THR) thr_s = $signed(d[23:0]);
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge ref_clk); while (!s_axi_arready);
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge ref_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        check({30'h0, s_axi_rresp}, (a > 8'h14) ? `AXI_SLVERR : `AXI_OKAY);
        @(posedge ref_clk);
    endtask
    function automatic int mag(input int v);
        return (v < 0) ? -v : v;
    endfunction
    // one dsp sample; the model updates states and flags as the block should
    task automatic sample(input logic tne);
        logic [2:0] nf, na;
        nf = fst;
        na = ast;
        for (int i = 0; i < 3; i++) begin
            fund_active_power[i] <= p[i][27:0];
            fund_reactive_power[i] <= q[i][27:0];
            apparent_power[i] <= s[i][27:0];
            nf[i] = thr_a >= 0 && thr_r >= 0 && mag(p[i]) <= thr_a && mag(q[i]) <= thr_r;
            na[i] = thr_s >= 0 && mag(s[i]) <= thr_s;
        end
        power_valid <= 1'b1;
        total_noload_event <= tne;
        @(posedge ref_clk);
        power_valid <= 1'b0;
        total_noload_event <= 1'b0;
        flags |= {29'h0, na != ast, nf != fst, tne};
        fst = nf;
        ast = na;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check({29'h0, fund_accumulate_en}, {29'h0, ~fst});
        check({29'h0, apparent_accumulate_en}, {29'h0, ~ast});
        check({31'h0, interrupt_line_second_n}, {31'h0, (flags & en) == 0});
        @(posedge ref_clk);
    endtask
    // status first, then phase states, then the write-back that clears
    task automatic service();
        axi_read(`OFS_FLAGS_SECOND, st);
        check(st, flags);
        axi_read(`OFS_PHASE_STATE, rd);
        check(rd, {23'h0, ast, fst, 3'h0});
        axi_write(`OFS_FLAGS_SECOND, st);
        axi_write(`OFS_FLAGS_SECOND, flags);
        @(negedge ref_clk);
        check({31'h0, interrupt_line_second_n}, {31'h0, (flags & en) == 0});
        @(posedge ref_clk);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 0;
        power_valid = 0;
        total_noload_event = 0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        fund_active_power = '{default: 28'h0};
        fund_reactive_power = '{default: 28'h0};
        apparent_power = '{default: 28'h0};
        fails = 0;
        total_checks = 0;
        cycles = 0;
        thr_a = 0;
        thr_r = 0;
        thr_s = 0;
        en = 0;
        flags = 0;
        fst = 3'h0;
        ast = 3'h0;
        void'($urandom(32'hC66223A6));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check({31'h0, interrupt_line_second_n}, 32'h1);
        for (int a = 8'h08; a <= 8'h14; a += 4) begin
            axi_read(a[7:0], rd);
            check(rd, 32'h0);
        end
        axi_write(`OFS_APPARENT_THR, 32'hFFFFFFFF);
        axi_read(`OFS_APPARENT_THR, rd);
        check(rd, 32'h00FFFFFF);
        axi_write(8'h40, 32'h5);
        axi_read(8'h40, rd);
        check(rd, 32'h0);
        $display("test registers done");
        axi_write(`OFS_ACTIVE_THR, 32'h100);
        axi_write(`OFS_REACTIVE_THR, 32'h180);
        axi_write(`OFS_APPARENT_THR, 32'h200);
        axi_write(`OFS_ENABLE_SECOND, 32'h6);
        p = '{-256, 256, 257};
        q = '{-384, 0, 0};
        s = '{512, -512, 513};
        sample(1'b0);
        service();
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 3; i++) begin
                p[i] = int'($urandom_range(32'h600)) - 32'h300;
                q[i] = int'($urandom_range(32'h600)) - 32'h300;
                s[i] = int'($urandom_range(32'h600)) - 32'h300;
            end
            if (k % 8 == 0) begin
                axi_write(`OFS_ENABLE_SECOND, $urandom_range(7));
                axi_read(`OFS_ENABLE_SECOND, rd);
                check(rd, en);
            end
            sample($urandom_range(1));
            if (k % 3 == 2) service();
        end
        service();
        $display("test random loads done");
        p = '{32'h5000, 32'h5000, 32'h5000};
        s = p;
        sample(1'b0);
        service();
        axi_write(`OFS_ACTIVE_THR, 32'hFFFFFF);
        axi_write(`OFS_REACTIVE_THR, 32'h800000);
        axi_write(`OFS_APPARENT_THR, 32'h800000);
        p = '{0, 0, 0};
        q = p;
        s = p;
        sample(1'b0);
        service();
        $display("test disabled detectors done");
        close_out();
    end
endmodule
